// ---- rtl/stp_stack_pointer.sv ----
// stp_stack_pointer: stack top pointer, byte access through a shared temp byte,
// and the interrupt hold window that follows a low byte write
// assumes the core gives one retire pulse per instruction and never drives
// a read and a write strobe together; all inputs are synchronous to clk
// the temp byte is shared by the read and write pairs, so software must keep
// each pair uninterrupted; the hold window only covers the write pair
// any write on the i/o bus counts as an i/o memory write for the hold window
// a retire pulse in the cycle of the low byte write itself is not counted
// a high byte write wins over a core stack adjustment in the same cycle
// read data come from flops and stand for the one cycle after the strobe
//
// Overview of operation
// - register holds current stack top address
// - reset loads highest internal sram address
// - only needed bits exist, others read zero
// - low byte at base, high at base+1
// - low write holds interrupts four instructions
// - low write to temp, copied on high
// - low read latches high into temp
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module stp_stack_pointer #(
  parameter int PTR_BITS = 16, // implemented pointer bits
  parameter logic [15:0] SRAM_END = 16'hffff // highest internal sram address
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire stp_pkg::stp_io_req_s io_req,
  output logic [7:0] io_rdata,
  input wire stp_pkg::stp_stack_upd_s stack_upd,
  input wire logic instr_retired,
  output logic [15:0] stack_top_pointer,
  output logic irq_hold
);
  // implemented bit mask, upper bits forced to zero
  localparam logic [15:0] IMPL_MASK = 16'((32'h1 << PTR_BITS) - 32'h1);

  // refuse widths the byte pair cannot carry or a reset top that does not fit
  if (PTR_BITS < 1 || PTR_BITS > stp_pkg::PTR_MAX_BITS) begin
    $error("stp_stack_pointer: pointer width out of range");
  end
  // the reset top must be reachable with the implemented bits
  if ((SRAM_END & ~IMPL_MASK) != 16'h0000) begin
    $error("stp_stack_pointer: reset top does not fit the pointer width");
  end

  // offset decode used by both the write and read paths
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  // access decode and the small amount of state this block keeps
  logic [7:0] temp_byte; // shared temporary byte
  logic [2:0] hold_cnt; // instructions left in the hold window
  logic wr_low; // software writes the low byte
  logic wr_high; // software writes the high byte
  logic rd_low; // software reads the low byte
  logic rd_high; // software reads the high byte

  // byte pair decode, high byte one offset above the low byte
  assign wr_low = io_req.wr && hit(io_req.addr, stp_pkg::OFS_LOW_BYTE);
  assign wr_high = io_req.wr && hit(io_req.addr, stp_pkg::OFS_HIGH_BYTE);
  assign rd_low = io_req.rd && hit(io_req.addr, stp_pkg::OFS_LOW_BYTE);
  assign rd_high = io_req.rd && hit(io_req.addr, stp_pkg::OFS_HIGH_BYTE);

  // pointer itself; a software high byte write wins over a core adjustment,
  // since the core never adjusts while it executes an i/o store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_pointer <= SRAM_END & IMPL_MASK;
    end else if (wr_high) begin
      // whole word lands at once, low byte from the temp byte
      stack_top_pointer <= {io_req.wdata, temp_byte} & IMPL_MASK;
    end else if (stack_upd.load) begin
      stack_top_pointer <= stack_upd.value & IMPL_MASK;
    end
  end

  // temp byte is shared by read and write sequences, so an interleaved
  // access from an interrupt handler can corrupt a half-done pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_byte <= 8'h00;
    end else if (wr_low) begin
      temp_byte <= io_req.wdata;
    end else if (rd_low) begin
      temp_byte <= stack_top_pointer[15:8];
    end
  end

  // read data, valid in the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= stp_pkg::RD_IDLE;
    end else if (rd_low) begin
      io_rdata <= stack_top_pointer[7:0];
    end else if (rd_high) begin
      io_rdata <= temp_byte;
    end else begin
      // unmapped offsets and idle cycles read zero
      io_rdata <= stp_pkg::RD_IDLE;
    end
  end

  // hold window: reload on low byte write, any other i/o write ends it,
  // each retired instruction counts one down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= stp_pkg::HOLD_NONE;
    end else if (wr_low) begin
      hold_cnt <= stp_pkg::HOLD_INSTR;
    end else if (io_req.wr) begin
      hold_cnt <= stp_pkg::HOLD_NONE;
    end else if (instr_retired && hold_cnt != stp_pkg::HOLD_NONE) begin
      hold_cnt <= hold_cnt - 3'h1;
    end
  end

  // level to the interrupt controller, straight from the counter flops
  assign irq_hold = (hold_cnt != stp_pkg::HOLD_NONE);

  // high byte write commits temp and the written byte together
  chk_high_commit: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_high |=> stack_top_pointer == ({$past(io_req.wdata), $past(temp_byte)} & IMPL_MASK))
    else $error("high byte write did not commit the pair");

  // low byte write loads the temp byte and leaves the pointer alone
  chk_low_staged: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_low && !stack_upd.load) |=>
      (temp_byte == $past(io_req.wdata)) && $stable(stack_top_pointer))
    else $error("low byte write changed the pointer or missed temp");

  // low read returns live low byte next cycle
  chk_low_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_low |=> io_rdata == $past(stack_top_pointer[7:0]))
    else $error("low byte read returned wrong data");

  // high read after low read returns the value latched at the low read
  chk_high_latched: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_low ##1 rd_high |=> io_rdata == $past(stack_top_pointer[15:8], 2))
    else $error("high byte read did not return the latched byte");

  // unimplemented bits always zero
  chk_unused_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (stack_top_pointer & ~IMPL_MASK) == 16'h0000)
    else $error("unimplemented pointer bits set");

  // core stack adjustment lands when software is not writing the high byte
  chk_core_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    (stack_upd.load && !wr_high) |=> stack_top_pointer == (stack_upd.value & IMPL_MASK))
    else $error("stack adjustment lost");

  // hold opens right after a low byte write
  chk_hold_opens: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_low |=> irq_hold)
    else $error("interrupt hold not raised after low byte write");

  // hold ends after four retired instructions with no writes between
  chk_hold_four: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_low ##1 (instr_retired && !io_req.wr) [*4] |=> !irq_hold)
    else $error("interrupt hold longer than four instructions");

  // hold still stands after only three retired instructions
  chk_hold_three: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_low ##1 (instr_retired && !io_req.wr) [*3] |=> irq_hold)
    else $error("interrupt hold shorter than four instructions");

  // any other i/o write ends the hold
  chk_hold_write_end: assert property (
    @(posedge clk) disable iff (!rst_n)
    (irq_hold && io_req.wr && !wr_low) |=> !irq_hold)
    else $error("i/o write did not end the interrupt hold");

  // unmapped reads answer zero
  chk_unmapped_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (io_req.rd && !rd_low && !rd_high) |=> io_rdata == stp_pkg::RD_IDLE)
    else $error("unmapped read returned nonzero");

  // read data stand one cycle only, zero when no read was made
  chk_rdata_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !io_req.rd |=> io_rdata == stp_pkg::RD_IDLE)
    else $error("read data present without a read");

  // low read copies the live high byte into the temp byte
  chk_temp_latch: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_low |=> temp_byte == $past(stack_top_pointer[15:8]))
    else $error("low byte read did not latch the high byte");

  // high read answers from the temp byte, never the live pointer
  chk_high_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    rd_high |=> io_rdata == $past(temp_byte))
    else $error("high byte read not served from the temp byte");

  // pointer only moves on a high byte write or a core adjustment
  chk_ptr_stable: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!wr_high && !stack_upd.load) |=> $stable(stack_top_pointer))
    else $error("pointer changed without a cause");

  // each retired instruction inside the window counts one down
  chk_hold_count: assert property (
    @(posedge clk) disable iff (!rst_n)
    (irq_hold && instr_retired && !io_req.wr) |=> hold_cnt == $past(hold_cnt) - 3'h1)
    else $error("hold window did not count a retired instruction");

  // window counter never exceeds the documented instruction count
  chk_hold_bound: assert property (
    @(posedge clk) disable iff (!rst_n)
    hold_cnt <= stp_pkg::HOLD_INSTR)
    else $error("hold window counter out of range");
endmodule

// ---- rtl/stp_pkg.sv ----
// stp_pkg: constants and carrier types for the cpu stack pointer register pair
// assumes an 8-bit i/o bus with 6-bit register offsets, one clock, async reset
package stp_pkg;
  // i/o offsets of the byte pair, high byte sits one above the low byte
  localparam logic [5:0] OFS_LOW_BYTE = 6'h0d; // stack_pointer_low_byte
  localparam logic [5:0] OFS_HIGH_BYTE = 6'h0e; // stack_pointer_high_byte
  // architectural width, at most a 64 kbyte space
  localparam int PTR_MAX_BITS = 16;
  // instructions during which interrupts stay held after a low byte write
  localparam logic [2:0] HOLD_INSTR = 3'h4;
  localparam logic [2:0] HOLD_NONE = 3'h0;
  // value on the read port for offsets this block does not own
  localparam logic [7:0] RD_IDLE = 8'h00;

  // one i/o access from the cpu core
  typedef struct packed {
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
    logic [5:0] addr; // register offset
    logic [7:0] wdata; // write byte
  } stp_io_req_s;

  // stack adjustment from push, pop, call and return
  typedef struct packed {
    logic load; // one-cycle pulse
    logic [15:0] value; // new stack top
  } stp_stack_upd_s;
endpackage

// ---- verification/stp_core_model.sv ----
// stp_core_model: stand-in for the cpu core that issues i/o accesses
// assumes clk comes from the bench; every request changes just after a rising edge
`timescale 1ns/100ps
module stp_core_model (
  input wire logic clk,
  output stp_pkg::stp_io_req_s io_req,
  input wire logic [7:0] io_rdata,
  output stp_pkg::stp_stack_upd_s stack_upd,
  output logic instr_retired
);
  // idle bus at time zero
  initial begin
    io_req = '0;
    stack_upd = '0;
    instr_retired = 1'b0;
  end
  // one write cycle; data inverted after, so a stale byte never looks valid
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    io_req.wr <= 1'b0;
    io_req.wdata <= ~d;
    #1;
  endtask
  // one read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: io_req.wdata};
    @(posedge clk);
    io_req.rd <= 1'b0;
    #1;
    d = io_rdata;
  endtask
  // two writes with no gap, e.g. low then high byte
  task automatic wr2(input logic [5:0] a0, input logic [7:0] d0,
                     input logic [5:0] a1, input logic [7:0] d1);
    @(posedge clk);
    io_req <= '{wr: 1'b1, rd: 1'b0, addr: a0, wdata: d0};
    @(posedge clk);
    io_req <= '{wr: 1'b1, rd: 1'b0, addr: a1, wdata: d1};
    @(posedge clk);
    io_req.wr <= 1'b0;
    io_req.wdata <= ~d1;
    #1;
  endtask
  // two reads with no gap; each byte taken in the cycle after its strobe
  task automatic rd2(input logic [5:0] a0, input logic [5:0] a1,
                     output logic [7:0] d0, output logic [7:0] d1);
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b1, addr: a0, wdata: io_req.wdata};
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b1, addr: a1, wdata: io_req.wdata};
    #1;
    d0 = io_rdata;
    @(posedge clk);
    io_req.rd <= 1'b0;
    #1;
    d1 = io_rdata;
  endtask
  // core stack adjustment pulse
  task automatic upd(input logic [15:0] v);
    @(posedge clk);
    stack_upd <= '{load: 1'b1, value: v};
    @(posedge clk);
    stack_upd.load <= 1'b0;
    #1;
  endtask
  // n back to back retire pulses
  task automatic retire(input int n);
    @(posedge clk);
    instr_retired <= 1'b1;
    repeat (n - 1) @(posedge clk);
    @(posedge clk);
    instr_retired <= 1'b0;
    #1;
  endtask
endmodule

// ---- verification/stp_stack_pointer_tb_top.sv ----
// stp_stack_pointer_tb_top: directed tests of the stack pointer byte pair
// assumes a 12-bit pointer so the unimplemented top nibble is exercised
`timescale 1ns/100ps
module stp_stack_pointer_tb_top;
  logic clk, rst_n, irq_hold, instr_retired;
  logic [7:0] io_rdata, d, d2;
  logic [15:0] stack_top_pointer;
  stp_pkg::stp_io_req_s io_req;
  stp_pkg::stp_stack_upd_s stack_upd;
  int err_count = 0, n_tests = 0, cycles = 0;
  // small pointer, reset top fits in 12 bits
  stp_stack_pointer #(.PTR_BITS(12), .SRAM_END(16'h0dff)) stp_stack_pointer_i (.clk(clk),
    .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata), .stack_upd(stack_upd),
    .instr_retired(instr_retired), .stack_top_pointer(stack_top_pointer), .irq_hold(irq_hold));
  stp_core_model stp_core_model_i (.clk(clk), .io_req(io_req), .io_rdata(io_rdata),
    .stack_upd(stack_upd), .instr_retired(instr_retired));
  // compare helper, four-state exact
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, tests need well under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(stack_top_pointer, 16'h0dff);
    stp_core_model_i.rd(stp_pkg::OFS_LOW_BYTE, d); check(d, 8'hff);
    stp_core_model_i.rd(stp_pkg::OFS_HIGH_BYTE, d); check(d, 8'h0d);
    stp_core_model_i.wr(stp_pkg::OFS_LOW_BYTE, 8'h34); check(stack_top_pointer, 16'h0dff);
    check(irq_hold, 1'b1);
    stp_core_model_i.retire(3); check(irq_hold, 1'b1);
    stp_core_model_i.retire(1); check(irq_hold, 1'b0);
    stp_core_model_i.wr(stp_pkg::OFS_HIGH_BYTE, 8'hab); check(stack_top_pointer, 16'h0b34);
    stp_core_model_i.rd(stp_pkg::OFS_LOW_BYTE, d); check(d, 8'h34);
    stp_core_model_i.rd(stp_pkg::OFS_HIGH_BYTE, d); check(d, 8'h0b);
    // another i/o write ends the hold early
    stp_core_model_i.wr(stp_pkg::OFS_LOW_BYTE, 8'h00); check(irq_hold, 1'b1);
    stp_core_model_i.wr(6'h0f, 8'h55); check(irq_hold, 1'b0);
    stp_core_model_i.rd(6'h0f, d); check(d, 8'h00);
    // high byte comes from the copy taken at the low read
    stp_core_model_i.rd(stp_pkg::OFS_LOW_BYTE, d); check(d, 8'h34);
    stp_core_model_i.upd(16'hf123); check(stack_top_pointer, 16'h0123);
    stp_core_model_i.rd(stp_pkg::OFS_HIGH_BYTE, d); check(d, 8'h0b);
    // back to back pair write, the high write also ends the hold
    stp_core_model_i.wr2(stp_pkg::OFS_LOW_BYTE, 8'h78, stp_pkg::OFS_HIGH_BYTE, 8'h05);
    check(stack_top_pointer, 16'h0578);
    check(irq_hold, 1'b0);
    // back to back pair read
    stp_core_model_i.rd2(stp_pkg::OFS_LOW_BYTE, stp_pkg::OFS_HIGH_BYTE, d, d2);
    check(d, 8'h78);
    check(d2, 8'h05);
    finish_test();
  end
endmodule
